// *** axil_slave.sv ***
// axi4-lite slave front end: turns bus beats into register strobes
`timescale 1ns/1ps

module axil_slave
    import flash_dl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // bus side
    input wire axil_m2s_t axiIn,
    output axil_s2m_t axiOut,
    // register side, write
    output logic wrEn,
    output logic [31:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrOk,
    // register side, read
    output logic rdEn,
    output logic [31:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdOk
);

    // ==========================================================
    // holding registers for address and data, either order
    logic awFull_reg, awFull_next;
    logic wFull_reg, wFull_next;
    logic [31:0] awAddr_reg, awAddr_next;
    logic [31:0] wData_reg, wData_next;
    logic [3:0] wStrb_reg, wStrb_next;
    axil_s2m_t out_reg, out_next;

    // write fires once both halves are held and no response pends
    assign wrEn = awFull_reg && wFull_reg && !out_reg.bvalid;
    assign wrAddr = awAddr_reg;
    assign wrData = wData_reg;
    assign wrStrb = wStrb_reg;
    // read is taken straight off the address channel
    assign rdEn = axiIn.arvalid && out_reg.arready;
    assign rdAddr = axiIn.araddr;
    assign axiOut = out_reg;

    // next-state of the channel handshakes
    always_comb
    begin
        awFull_next = awFull_reg;
        wFull_next = wFull_reg;
        awAddr_next = awAddr_reg;
        wData_next = wData_reg;
        wStrb_next = wStrb_reg;
        out_next = out_reg;
        if (axiIn.awvalid && out_reg.awready)
        begin
            awFull_next = 1'b1;
            awAddr_next = axiIn.awaddr;
        end
        if (axiIn.wvalid && out_reg.wready)
        begin
            wFull_next = 1'b1;
            wData_next = axiIn.wdata;
            wStrb_next = axiIn.wstrb;
        end
        if (out_reg.bvalid && axiIn.bready)
            out_next.bvalid = 1'b0;
        if (wrEn)
        begin
            awFull_next = 1'b0;
            wFull_next = 1'b0;
            out_next.bvalid = 1'b1;
            out_next.bresp = wrOk ? `RESP_OKAY : `RESP_SLVERR;
        end
        // ready comes from a flop, so it drops as soon as a half is held
        out_next.awready = !awFull_next;
        out_next.wready = !wFull_next;
        if (out_reg.rvalid && axiIn.rready)
            out_next.rvalid = 1'b0;
        if (rdEn)
        begin
            out_next.rvalid = 1'b1;
            out_next.rdata = rdOk ? rdData : 32'h0000_0000;
            out_next.rresp = rdOk ? `RESP_OKAY : `RESP_SLVERR;
        end
        // one read in flight at most
        out_next.arready = !out_next.rvalid;
    end

    // register stage
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            awFull_reg <= 1'b0;
            wFull_reg <= 1'b0;
            awAddr_reg <= 32'h0000_0000;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            out_reg <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
        end
        else
        begin
            awFull_reg <= awFull_next;
            wFull_reg <= wFull_next;
            awAddr_reg <= awAddr_next;
            wData_reg <= wData_next;
            wStrb_reg <= wStrb_next;
            out_reg <= out_next;
        end
    end

endmodule

// *** flash_dl_cfg.svh ***
// constants for the flash download and ram emulation block
`ifndef FLASH_DL_CFG_SVH
`define FLASH_DL_CFG_SVH

// ==========================================================
// register byte addresses on the axi4-lite bus
`define REG_DEST_OFF 32'h0000_0000
`define REG_EMU_OFF 32'h0000_0004
`define REG_CTRL_OFF 32'h0000_0008
`define REG_START_OFF 32'h0000_000C

// ==========================================================
// reset values
`define DEST_RST 8'h00
`define EMU_RST 4'h0

// ==========================================================
// field positions
`define DEST_ERR_BIT 7
`define CTRL_START_BIT 0
`define CTRL_BUSY_BIT 1

// ==========================================================
// download start addresses for destination codes 0 to 3
`define DEST_ADDR_0 24'hFF7000
`define DEST_ADDR_1 24'hFFB000
`define DEST_ADDR_2 24'hFFD000
`define DEST_ADDR_3 24'hFFE800
`define DEST_CODE_MAX 7'h03

// ==========================================================
// download length: a 2-kbyte routine
`define DL_SIZE_BYTES 2048
`define DL_LAST_IDX (`DL_SIZE_BYTES - 1)

// ==========================================================
// emulation overlay: 4-kbyte flash blocks, ram window base
`define FLASH_BLK_SHIFT 12
`define EMU_RAM_BASE 24'hFFF000

// ==========================================================
// axi response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** flash_dl_checker.sv ***
// assertion checker for the flash download and ram emulation block
`timescale 1ns/1ps

module flash_dl_checker
    import flash_dl_pkg::*;
(
    // clock, reset, standby pin
    input wire logic clk,
    input wire logic srst,
    input wire logic hwStandby,
    // register bus
    input wire axil_m2s_t axiIn,
    input wire axil_s2m_t axiOut,
    // download side
    input wire logic [10:0] srcAddr,
    input wire logic [7:0] srcData,
    input wire ram_wr_t ramWr,
    input wire logic dlBusy,
    // overlay side
    input wire logic flashPeProtect,
    input wire logic [23:0] cpuAddr,
    input wire logic ovlHit,
    input wire logic [23:0] ovlAddr
);
    // ==========================================================
    // one clock domain, so one default clock and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ==========================================================
    // steps of the copy and of a register write
    sequence s_copy_start;
        !ramWr.valid ##1 (ramWr.valid && dlBusy) [*8];
    endsequence
    sequence s_write_done;
        axiOut.bvalid;
    endsequence

    // protection only changes as a register write completes or standby lands
    property p_protect_rise;
        $rose(flashPeProtect) |-> s_write_done;
    endproperty
    property p_protect_fall;
        $fell(flashPeProtect) |-> axiOut.bvalid || $past(hwStandby, 2) ||
            $past(hwStandby, 3) || $past(hwStandby, 4);
    endproperty
    // a hit lands inside the ram window with the offset kept
    property p_hit_redirect;
        ovlHit && !$past(srst) |-> ovlAddr == {12'hFFF, $past(cpuAddr[11:0])};
    endproperty
    property p_hit_range;
        ovlHit && !$past(srst) |-> $past(cpuAddr[23:15]) == 9'h000 && $past(flashPeProtect);
    endproperty
    // a miss passes the address through untouched
    property p_miss_pass;
        !ovlHit && !$past(srst) |-> ovlAddr == $past(cpuAddr);
    endproperty
    // copy starts only from a register write and runs at one byte a cycle
    property p_busy_cause;
        $rose(dlBusy) |-> s_write_done;
    endproperty
    property p_copy_start;
        $rose(dlBusy) |-> s_copy_start;
    endproperty
    property p_copy_step;
        ramWr.valid && $past(ramWr.valid) |-> ramWr.addr == $past(ramWr.addr) + 24'h000001;
    endproperty
    property p_first_addr;
        $rose(ramWr.valid) |->
            ramWr.addr inside {24'hFF7000, 24'hFFB000, 24'hFFD000, 24'hFFE800};
    endproperty
    property p_src_pair;
        ramWr.valid && dlBusy |->
            ramWr.data == $past(srcData) && ramWr.addr[10:0] == srcAddr - 11'h001;
    endproperty

    a_protect_rise: assert property (p_protect_rise) else $error("protect rose without write");
    a_protect_fall: assert property (p_protect_fall) else $error("protect fell without cause");
    a_hit_redirect: assert property (p_hit_redirect) else $error("hit address not redirected");
    a_hit_range: assert property (p_hit_range) else $error("hit outside emulated blocks");
    a_miss_pass: assert property (p_miss_pass) else $error("miss address altered");
    a_busy_cause: assert property (p_busy_cause) else $error("copy began without write");
    a_copy_start: assert property (p_copy_start) else $error("copy pulses not back to back");
    a_copy_step: assert property (p_copy_step) else $error("copy address did not step");
    a_first_addr: assert property (p_first_addr) else $error("copy start address wrong");
    a_src_pair: assert property (p_src_pair) else $error("copied byte mismatch");
endmodule

bind flash_download_and_ram_emulation flash_dl_checker u_chk (
    .clk(clk), .srst(srst), .hwStandby(hwStandby), .axiIn(axiIn), .axiOut(axiOut),
    .srcAddr(srcAddr), .srcData(srcData), .ramWr(ramWr), .dlBusy(dlBusy),
    .flashPeProtect(flashPeProtect), .cpuAddr(cpuAddr), .ovlHit(ovlHit), .ovlAddr(ovlAddr)
);

// *** flash_dl_pkg.sv ***
// types and shared functions for the flash download and ram emulation block
`include "flash_dl_cfg.svh"

package flash_dl_pkg;

    // ==========================================================
    // axi4-lite channels, master to slave
    typedef struct packed {
        logic [31:0] awaddr;
        logic [2:0] awprot;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic [2:0] arprot;
        logic arvalid;
        logic rready;
    } axil_m2s_t;

    // axi4-lite channels, slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_s2m_t;

    // ==========================================================
    // one byte written into on-chip ram by the download
    typedef struct packed {
        logic valid;
        logic [23:0] addr;
        logic [7:0] data;
    } ram_wr_t;

    // download destination register layout
    typedef struct packed {
        logic rangeErr;
        logic [6:0] code;
    } dest_reg_t;

    // emulation overlay control, low nibble only
    typedef struct packed {
        logic emulationSelect;
        logic [2:0] overlayArea;
    } emu_ctrl_t;

    // download sequencer states
    typedef enum logic [0:0] {
        DL_IDLE,
        DL_COPY
    } dl_state_t;

    // ==========================================================
    // destination code to ram start address
    function automatic logic [23:0] destStart(input logic [1:0] code);
        logic [23:0] a;
        unique case (code)
            2'h0: a = `DEST_ADDR_0;
            2'h1: a = `DEST_ADDR_1;
            2'h2: a = `DEST_ADDR_2;
            2'h3: a = `DEST_ADDR_3;
        endcase
        return a;
    endfunction

endpackage

// *** flash_download_and_ram_emulation.sv ***
// top of the flash download sequencer and ram emulation control
//
// Contract
// - code 0 to FF7000, code 1 to FFB000
// - code 2 to FFD000, code 3 to FFE800
// - codes 4 and up: flag error, abort
// - range checked at start-copy, not write
// - download fills 2 kbytes from start
// - emulation register cleared by reset, hw standby
// - software standby keeps emulation register
// - upper nibble reads zero, software writes zero
// - select set: emulate, protect all blocks
// - select clear: no emulation, protection off
// - area field with select picks block
// - area n maps block at n*1000h
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module flash_download_and_ram_emulation
    import flash_dl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // hardware standby pin
    input wire logic hwStandby,
    // axi4-lite register bus
    input wire axil_m2s_t axiIn,
    output axil_s2m_t axiOut,
    // built-in routine source, srcData taken in the same cycle as srcAddr
    output logic [10:0] srcAddr,
    input wire logic [7:0] srcData,
    // on-chip ram write port for the download
    output ram_wr_t ramWr,
    output logic dlBusy,
    // flash control and cpu address overlay
    output logic flashPeProtect,
    input wire logic [23:0] cpuAddr,
    output logic ovlHit,
    output logic [23:0] ovlAddr
);

    // ==========================================================
    // register decode
    // ==========================================================

    // true when a bus address selects the given register word
    function automatic logic isReg(input logic [31:0] a, input logic [31:0] off);
        return a == off;
    endfunction

    // bus strobes from the front end
    logic wrEn;
    logic [31:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrOk;
    logic rdEn;
    logic [31:0] rdAddr;
    logic [31:0] rdData;
    logic rdOk;

    // per-register write hits, byte lane 0 only
    logic wrDest;
    logic wrEmu;
    logic wrCtrl;

    axil_slave busIf (
        .clk(clk),
        .srst(srst),
        .axiIn(axiIn),
        .axiOut(axiOut),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdEn(rdEn),
        .rdAddr(rdAddr),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    // the start-address word is read only, so writes to it are refused
    always_comb
    begin
        wrOk = isReg(wrAddr, `REG_DEST_OFF) || isReg(wrAddr, `REG_EMU_OFF)
            || isReg(wrAddr, `REG_CTRL_OFF);
        wrDest = wrEn && wrStrb[0] && isReg(wrAddr, `REG_DEST_OFF);
        wrEmu = wrEn && wrStrb[0] && isReg(wrAddr, `REG_EMU_OFF);
        wrCtrl = wrEn && wrStrb[0] && isReg(wrAddr, `REG_CTRL_OFF);
    end

    // ==========================================================
    // hardware standby synchroniser
    // ==========================================================

    logic stbyMeta_reg; // first stage, read only by the second
    logic stbySync_reg; // safe to use

    // the pin comes from outside, two flops before any use
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stbyMeta_reg <= 1'b0;
            stbySync_reg <= 1'b0;
        end
        else
        begin
            stbyMeta_reg <= hwStandby;
            stbySync_reg <= stbyMeta_reg;
        end
    end

    // ==========================================================
    // emulation overlay control register
    // ==========================================================

    emu_ctrl_t emu_reg, emu_next; // select bit and area field
    logic prot_reg, prot_next; // program/erase block on all flash

    // software writes land here; the mode restriction and the settle
    // gap after a write are the software's duty, not checked here
    always_comb
    begin
        emu_next = emu_reg;
        if (wrEmu)
            emu_next = emu_ctrl_t'(wrData[3:0]);
        // only power-on reset and hardware standby clear it
        if (stbySync_reg)
            emu_next = emu_ctrl_t'(`EMU_RST);
        // protection follows the select bit directly
        prot_next = emu_next.emulationSelect;
    end

    // register stage of the emulation control
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            emu_reg <= emu_ctrl_t'(`EMU_RST);
            prot_reg <= 1'b0;
        end
        else
        begin
            emu_reg <= emu_next;
            prot_reg <= prot_next;
        end
    end

    assign flashPeProtect = prot_reg;

    // the overlay itself lives in its own module
    overlay_map ovl (
        .clk(clk),
        .srst(srst),
        .emuCtrl(emu_reg),
        .cpuAddr(cpuAddr),
        .ovlHit(ovlHit),
        .ovlAddr(ovlAddr)
    );

    // ==========================================================
    // download destination register and sequencer
    // ==========================================================

    dest_reg_t dest_reg, dest_next; // error flag and code
    dl_state_t state_reg, state_next; // sequencer state
    logic [10:0] idx_reg, idx_next; // byte index within routine
    logic [23:0] start_reg, start_next; // ram start latched at trigger
    ram_wr_t ramWr_reg, ramWr_next; // ram write beat
    logic busy_reg, busy_next; // download in progress
    logic trigger; // start-copy written with a one
    logic codeBad; // code outside 0 to 3

    assign trigger = wrCtrl && wrData[`CTRL_START_BIT];
    // a seven-bit field above 3 covers every prohibited code
    assign codeBad = dest_next.code > `DEST_CODE_MAX;

    // next state of the register and the copy loop
    always_comb
    begin
        dest_next = dest_reg;
        state_next = state_reg;
        idx_next = idx_reg;
        start_next = start_reg;
        ramWr_next = ramWr_reg;
        ramWr_next.valid = 1'b0;
        // software write first, so a hardware set below wins
        if (wrDest)
            dest_next = dest_reg_t'(wrData[7:0]);
        unique case (state_reg)
            DL_IDLE:
            begin
                // the code is judged only now, not when written
                if (trigger)
                begin
                    if (codeBad)
                        dest_next.rangeErr = 1'b1;
                    else
                    begin
                        start_next = destStart(dest_next.code[1:0]);
                        idx_next = 11'h000;
                        state_next = DL_COPY;
                    end
                end
            end
            DL_COPY:
            begin
                // srcData belongs to idx_reg, presented on srcAddr this cycle
                ramWr_next.valid = 1'b1;
                ramWr_next.addr = start_reg + 24'(idx_reg);
                ramWr_next.data = srcData;
                if (idx_reg == 11'(`DL_LAST_IDX))
                    state_next = DL_IDLE;
                else
                    idx_next = idx_reg + 11'h001;
            end
        endcase
        busy_next = state_next == DL_COPY;
    end

    // register stage of the sequencer
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dest_reg <= dest_reg_t'(`DEST_RST);
            state_reg <= DL_IDLE;
            idx_reg <= 11'h000;
            start_reg <= 24'h000000;
            ramWr_reg <= '0;
            busy_reg <= 1'b0;
        end
        else
        begin
            dest_reg <= dest_next;
            state_reg <= state_next;
            idx_reg <= idx_next;
            start_reg <= start_next;
            ramWr_reg <= ramWr_next;
            busy_reg <= busy_next;
        end
    end

    assign srcAddr = idx_reg;
    assign ramWr = ramWr_reg;
    assign dlBusy = busy_reg;

    // ==========================================================
    // read mux
    // ==========================================================

    // upper bits of each byte register read as zero
    always_comb
    begin
        rdOk = 1'b1;
        rdData = 32'h0000_0000;
        if (isReg(rdAddr, `REG_DEST_OFF))
            rdData[7:0] = dest_reg;
        else if (isReg(rdAddr, `REG_EMU_OFF))
            rdData[3:0] = emu_reg;
        else if (isReg(rdAddr, `REG_CTRL_OFF))
            rdData[`CTRL_BUSY_BIT] = busy_reg;
        else if (isReg(rdAddr, `REG_START_OFF))
            rdData[23:0] = destStart(dest_reg.code[1:0]);
        else
            rdOk = 1'b0;
    end

endmodule

// *** flash_download_and_ram_emulation_bench.sv ***
// self-checking bench for the flash download and ram emulation block
`timescale 1ns/1ps

module flash_download_and_ram_emulation_bench import flash_dl_pkg::*;;
    // ==========================================================
    // design connections and bookkeeping
    logic clk;
    logic srst;
    logic hwStandby;
    axil_m2s_t axiIn;
    axil_s2m_t axiOut;
    logic [10:0] srcAddr;
    logic [7:0] srcData;
    ram_wr_t ramWr;
    logic dlBusy;
    logic flashPeProtect;
    logic [23:0] cpuAddr;
    logic ovlHit;
    logic [23:0] ovlAddr;
    int error_cnt;
    int checks;
    int cycles;
    int dlCnt;
    logic [23:0] dlStart;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [2:0] blk;
    logic [23:0] starts [4] = '{24'hFF7000, 24'hFFB000, 24'hFFD000, 24'hFFE800};
    logic [6:0] bad [2] = '{7'h04, 7'h7F};

    // routine rom model: a pattern unlike the index so swapped bytes show
    function automatic logic [7:0] romByte(input logic [10:0] i);
        return i[7:0] ^ {5'h00, i[10:8]} ^ 8'hA5;
    endfunction
    assign srcData = romByte(srcAddr);

    flash_download_and_ram_emulation dut (
        .clk(clk), .srst(srst), .hwStandby(hwStandby), .axiIn(axiIn), .axiOut(axiOut),
        .srcAddr(srcAddr), .srcData(srcData), .ramWr(ramWr), .dlBusy(dlBusy),
        .flashPeProtect(flashPeProtect), .cpuAddr(cpuAddr), .ovlHit(ovlHit), .ovlAddr(ovlAddr)
    );

    // ==========================================================
    // clock, hang guard, copy monitor
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // the run needs about ten thousand cycles; three times that means a hang
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    // every ram byte is checked against the running index of the copy
    always @(posedge clk)
        if (ramWr.valid === 1'b1)
        begin
            chk({8'h00, ramWr.addr}, {8'h00, dlStart + dlCnt[23:0]});
            chk({24'h0, ramWr.data}, {24'h0, romByte(dlCnt[10:0])});
            dlCnt++;
        end

    // ==========================================================
    // compare, bus tasks, verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // an idle edge first keeps a ready from being driven twice in one step
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        axiIn.awaddr <= a;
        axiIn.wdata <= d;
        axiIn.wstrb <= 4'hF;
        axiIn.awvalid <= 1'b1;
        axiIn.wvalid <= 1'b1;
        axiIn.bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (axiIn.awvalid && axiOut.awready)
                axiIn.awvalid <= 1'b0;
            if (axiIn.wvalid && axiOut.wready)
                axiIn.wvalid <= 1'b0;
        end while (axiOut.bvalid !== 1'b1);
        r = axiOut.bresp;
        axiIn.bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        axiIn.araddr <= a;
        axiIn.arvalid <= 1'b1;
        axiIn.rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (axiIn.arvalid && axiOut.arready)
                axiIn.arvalid <= 1'b0;
        end while (axiOut.rvalid !== 1'b1);
        d = axiOut.rdata;
        r = axiOut.rresp;
        axiIn.rready <= 1'b0;
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        srst = 1'b1;
        hwStandby = 1'b0;
        axiIn = '0;
        cpuAddr = 24'h000000;
        dlStart = 24'h000000;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        // reset contents, unmapped read, write to the read-only word
        axi_read(32'h0000_0000, rd, rsp);
        chk(rd, 32'h0000_0000);
        axi_read(32'h0000_0004, rd, rsp);
        chk(rd, 32'h0000_0000);
        axi_read(32'h0000_0010, rd, rsp);
        chk({30'h0, rsp}, 32'h0000_0002);
        chk(rd, 32'h0000_0000);
        axi_write(32'h0000_000C, 32'h0000_0001, rsp);
        chk({30'h0, rsp}, 32'h0000_0002);
        // each overlay block: upper nibble written high yet reads zero
        for (int n = 0; n < 8; n++)
        begin
            blk = n[2:0];
            axi_write(32'h0000_0004, {24'h0, 4'hF, 1'b1, blk}, rsp);
            axi_read(32'h0000_0004, rd, rsp);
            chk(rd, {28'h0, 1'b1, blk});
            chk({31'h0, flashPeProtect}, 32'h0000_0001);
            cpuAddr <= {9'h000, blk, 12'hABC};
            repeat (2) @(posedge clk);
            chk({7'h0, ovlHit, ovlAddr}, {7'h0, 1'b1, 24'hFFFABC});
            cpuAddr <= {9'h000, blk ^ 3'h1, 12'hABC};
            repeat (2) @(posedge clk);
            chk({7'h0, ovlHit, ovlAddr}, {7'h0, 1'b0, 9'h000, blk ^ 3'h1, 12'hABC});
        end
        // emulation off: protection and redirection both gone
        axi_write(32'h0000_0004, 32'h0000_0000, rsp);
        chk({31'h0, flashPeProtect}, 32'h0000_0000);
        cpuAddr <= 24'h000ABC;
        repeat (2) @(posedge clk);
        chk({7'h0, ovlHit, ovlAddr}, {7'h0, 1'b0, 24'h000ABC});
        // hardware standby clears emulation only
        axi_write(32'h0000_0004, 32'h0000_0009, rsp);
        axi_write(32'h0000_0000, 32'h0000_0002, rsp);
        hwStandby <= 1'b1;
        repeat (6) @(posedge clk);
        hwStandby <= 1'b0;
        repeat (6) @(posedge clk);
        axi_read(32'h0000_0004, rd, rsp);
        chk({rd[30:0], flashPeProtect}, 32'h0000_0000);
        axi_read(32'h0000_0000, rd, rsp);
        chk(rd, 32'h0000_0002);
        // every legal code, with a second start while busy that must be ignored
        for (int c = 0; c < 4; c++)
        begin
            axi_write(32'h0000_0000, c, rsp);
            axi_read(32'h0000_000C, rd, rsp);
            chk(rd, {8'h00, starts[c]});
            dlCnt = 0;
            dlStart = starts[c];
            axi_write(32'h0000_0008, 32'h0000_0001, rsp);
            axi_read(32'h0000_0008, rd, rsp);
            chk(rd, 32'h0000_0002);
            axi_write(32'h0000_0008, 32'h0000_0001, rsp);
            for (int i = 0; i < 3000 && dlBusy !== 1'b0; i++)
                @(posedge clk);
            repeat (2) @(posedge clk);
            chk(32'(dlCnt), 32'd2048);
        end
        // out-of-range codes: accepted on write, refused at start
        foreach (bad[i])
        begin
            axi_write(32'h0000_0000, {25'h0, bad[i]}, rsp);
            axi_read(32'h0000_0000, rd, rsp);
            chk(rd, {25'h0, bad[i]});
            dlCnt = 0;
            axi_write(32'h0000_0008, 32'h0000_0001, rsp);
            axi_read(32'h0000_0000, rd, rsp);
            chk(rd, {24'h0, 1'b1, bad[i]});
            repeat (4) @(posedge clk);
            chk({dlCnt[30:0], dlBusy}, 32'h0000_0000);
        end
        report_and_stop();
    end
endmodule

// *** overlay_map.sv ***
// ram emulation overlay: redirects one 4-kbyte flash block into ram
`timescale 1ns/1ps

module overlay_map
    import flash_dl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control and cpu address
    input wire emu_ctrl_t emuCtrl,
    input wire logic [23:0] cpuAddr,
    // mapped result
    output logic ovlHit,
    output logic [23:0] ovlAddr
);

    logic hit_reg, hit_next; // address falls in the emulated block
    logic [23:0] addr_reg, addr_next; // address after the overlay

    // block n spans n*4k; only blocks 0 to 7 can match
    always_comb
    begin
        hit_next = emuCtrl.emulationSelect &&
            (cpuAddr[23:`FLASH_BLK_SHIFT] == 12'(emuCtrl.overlayArea));
        addr_next = cpuAddr;
        if (hit_next)
            addr_next = `EMU_RAM_BASE | {12'h000, cpuAddr[`FLASH_BLK_SHIFT-1:0]};
    end

    // registered so the outputs come from flops
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hit_reg <= 1'b0;
            addr_reg <= 24'h000000;
        end
        else
        begin
            hit_reg <= hit_next;
            addr_reg <= addr_next;
        end
    end

    assign ovlHit = hit_reg;
    assign ovlAddr = addr_reg;

endmodule
